//--- logic/fbr_pkg.sv
package fbr_pkg;

    // ****************************************
    // Register map (byte addresses)
    // ****************************************
    localparam logic [7:0] FBR_READ_CTRL_OFS = 8'h00;
    localparam logic [7:0] FBR_PATTERN_CTRL_OFS = 8'h04;
    localparam logic [7:0] FBR_WINDOW_BASE_OFS = 8'h08;
    localparam logic [7:0] FBR_BUF_DISP_OFS = 8'h0C;
    localparam logic [7:0] FBR_SRC_DISP_OFS = 8'h10;
    localparam logic [7:0] FBR_WRITE_CTRL_OFS = 8'h14;
    localparam logic [7:0] FBR_PAT_INDEX_OFS = 8'h18;
    localparam logic [7:0] FBR_PAT_DATA_OFS = 8'h1C;
    localparam logic [7:0] FBR_STATUS_OFS = 8'h20;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int FBR_SRC_RD_BIT = 0;
    localparam int FBR_DST_RD_BIT = 1;
    localparam int FBR_CODE_A_LSB = 2;
    localparam int FBR_CODE_B_LSB = 5;
    localparam int FBR_CODE_C_LSB = 8;
    localparam int FBR_TOP_LEFT_BIT = 11;
    localparam int FBR_SCAN_SHIFT_LSB = 12;
    localparam int FBR_PAT_EN_BIT = 0;
    localparam int FBR_WR_EN_BIT = 0;
    localparam int FBR_VAR_COLOUR_BIT = 1;

    // ****************************************
    // Sizes and reset values
    // ****************************************
    localparam int FBR_ADDR_W = 24;
    localparam int FBR_WORD_W = 32;
    localparam int FBR_STORE_DEPTH = 32;
    localparam int FBR_IDX_W = 5;
    localparam logic [31:0] FBR_REG_RESET = 32'h0000_0000;
    localparam logic [FBR_IDX_W-1:0] FBR_IDX_LAST = 5'h1F;

    // Mode bits as {pattern, source, destination}
    typedef logic [2:0] fbr_mode_t;
    localparam fbr_mode_t FBR_MODE_NONE = 3'h0;
    localparam fbr_mode_t FBR_MODE_PAT_ONLY = 3'h4;
    localparam fbr_mode_t FBR_MODE_PAT_DST = 3'h5;
    localparam fbr_mode_t FBR_MODE_PAT_LOAD = 3'h6;

    typedef enum logic [2:0] {
        FBR_ST_IDLE,
        FBR_ST_SRC_REQ,
        FBR_ST_SRC_WAIT,
        FBR_ST_DST_REQ,
        FBR_ST_DST_WAIT,
        FBR_ST_PAT
    } fbr_state_e;

    // Span from the rasteriser
    typedef struct packed {
        logic [15:0] x;
        logic [15:0] y;
        logic [31:0] mask;
    } fbr_span_s;

    // Operand pair towards the logic-op unit
    typedef struct packed {
        logic [31:0] src;
        logic [31:0] dst;
    } fbr_pair_s;

endpackage

//--- logic/fbr_addr_calc.sv
`timescale 1ns/1ps
// Combinational framebuffer address equations shared by span and pixel paths
module fbr_addr_calc (
    input wire logic [fbr_pkg::FBR_ADDR_W-1:0] window_origin_base,
    input wire logic [fbr_pkg::FBR_ADDR_W-1:0] buffer_displacement,
    input wire logic [fbr_pkg::FBR_ADDR_W-1:0] src_displacement,
    input wire logic [15:0] x,
    input wire logic [15:0] y,
    input wire logic [1:0] scan_shift,
    input wire logic [2:0] width_code_a,
    input wire logic [2:0] width_code_b,
    input wire logic [2:0] width_code_c,
    input wire logic top_left,
    output logic [fbr_pkg::FBR_ADDR_W-1:0] dst_addr,
    output logic [fbr_pkg::FBR_ADDR_W-1:0] src_addr
);
    import fbr_pkg::*;

    // ****************************************
    // Partial products
    // ****************************************
    // Each code adds one power of two; zero adds nothing
    function automatic logic [FBR_ADDR_W-1:0] part(input logic [2:0] code);
        logic [FBR_ADDR_W-1:0] r;
        r = '0;
        if (code != 3'h0) begin
            r = 24'h000010 << code;
        end
        return r;
    endfunction

    logic [FBR_ADDR_W-1:0] width;
    logic [15:0] row;
    logic [47:0] prod;
    logic [FBR_ADDR_W-1:0] row_ofs;
    logic [FBR_ADDR_W-1:0] origin;

    // Width from three codes, row divided by interleave factor
    always_comb begin
        width = part(width_code_a) + part(width_code_b) + part(width_code_c); // see R15
        row = y >> scan_shift; // see R14
        prod = {8'h00, width} * {32'h0000_0000, row};
        row_ofs = prod[FBR_ADDR_W-1:0];
        // Sums wrap at 24 bits; displacements are two's complement
        origin = top_left ? window_origin_base + row_ofs : window_origin_base - row_ofs; // see R11
        dst_addr = origin + {8'h00, x} + buffer_displacement; // see R10
        src_addr = dst_addr + src_displacement; // see R13
    end

endmodule // fbr_addr_calc

//--- logic/fbr_span_read.sv
// The strobed register port and the address map are this design's own decisions.
`timescale 1ns/1ps
// Operation
// R1 - Span read operation chosen from pattern, source and destination enable bits together.
// R2 - All three clear: no span reads, no pattern data; host supplies colour.
// R3 - Destination only: read destination spans; pattern store becomes indeterminate.
// R4 - Source only: read source spans; pattern store overwritten, indeterminate.
// R5 - Source and destination: source into store first, then destination interleaved.
// R6 - Pattern only: no reads, pattern store feeds variable-colour write.
// R7 - Pattern and destination: destination interleaved with store, store kept intact.
// R8 - Pattern and source: source saved into store, nothing to logic-op unit.
// R9 - Pattern load: variable-colour write draws nothing; constant-colour write proceeds.
// R10 - Pixel offset added to all addresses, source offset to copy sources.
// R11 - Address is base plus offset plus X, minus or plus (Y/S)*W.
// R12 - Destination address used for writes and destination reads.
// R13 - Source address only for source reads; offset is destination-to-source.
// R14 - Y divided by scanline interval S before multiplying by width.
// R15 - Only widths from three partial-product code fields supported.
// R16 - Span addresses use the same equations as single-pixel addresses.
// R17 - Software keeps both offsets zero for ordinary rendering.
// R18 - Software changes pixel offset, not window base, for alternative buffers.
// R19 - Software enables depth writes only on the last buffer pass.
// R20 - Window base held as 24-bit unsigned value.
// R21 - Pixel and source offsets held as 24-bit two's complement.
// R22 - Pattern store holds 32 entries of 32 bits.
// R23 - Mode bits sampled at span start, held until the span completes.
// R24 - Address sums truncated to 24 bits, wrapping on overflow.
module fbr_span_read (
    input wire logic clock,
    input wire logic rst,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Spans from the rasteriser
    input wire logic span_valid,
    input wire fbr_pkg::fbr_span_s span_in,
    output logic span_ready,
    output logic span_done,
    // Framebuffer read port
    output logic mem_req_valid,
    output logic [fbr_pkg::FBR_ADDR_W-1:0] mem_req_addr,
    input wire logic mem_req_ready,
    input wire logic mem_rsp_valid,
    input wire logic [31:0] mem_rsp_data,
    // Operand stream to logic-op / write units
    output logic out_valid,
    output fbr_pkg::fbr_pair_s out_data,
    input wire logic out_ready,
    // Write unit controls
    output logic [fbr_pkg::FBR_ADDR_W-1:0] wr_addr,
    output logic draw_enable
);
    import fbr_pkg::*;

    // ****************************************
    // Registers
    // ****************************************
    logic [31:0] rd_ctrl_q, rd_ctrl_d;
    logic pat_en_q, pat_en_d;
    logic [FBR_ADDR_W-1:0] base_q, base_d, pdisp_q, pdisp_d, sdisp_q, sdisp_d;
    logic [1:0] wr_ctrl_q, wr_ctrl_d;
    logic [FBR_IDX_W-1:0] pidx_q, pidx_d;
    logic [31:0] rdata_q, rdata_d;
    logic [31:0] store_q [FBR_STORE_DEPTH];
    logic st_we;
    logic [FBR_IDX_W-1:0] st_idx;
    logic [31:0] st_wdata;

    fbr_state_e state_q, state_d;
    fbr_mode_t mode_q, mode_d;
    fbr_span_s span_q, span_d;
    logic [FBR_IDX_W-1:0] idx_q, idx_d;
    logic [FBR_ADDR_W-1:0] sbase_q, sbase_d, dbase_q, dbase_d;
    logic [FBR_ADDR_W-1:0] addr_q, addr_d;
    logic out_valid_q, out_valid_d;
    fbr_pair_s out_q, out_d;
    logic done_q, done_d;
    logic [FBR_ADDR_W-1:0] calc_dst, calc_src;
    logic accept, host_st_wr;

    // Address equations, same block for span and pixel use
    fbr_addr_calc u_calc (
        .window_origin_base(base_q),
        .buffer_displacement(pdisp_q),
        .src_displacement(sdisp_q),
        .x(span_in.x),
        .y(span_in.y),
        .scan_shift(rd_ctrl_q[FBR_SCAN_SHIFT_LSB +: 2]),
        .width_code_a(rd_ctrl_q[FBR_CODE_A_LSB +: 3]),
        .width_code_b(rd_ctrl_q[FBR_CODE_B_LSB +: 3]),
        .width_code_c(rd_ctrl_q[FBR_CODE_C_LSB +: 3]),
        .top_left(rd_ctrl_q[FBR_TOP_LEFT_BIT]),
        .dst_addr(calc_dst),
        .src_addr(calc_src)
    ); // see R16

    // ****************************************
    // Register port
    // ****************************************
    // Host store writes are dropped while a span runs; engine owns the store then
    assign host_st_wr = reg_wr && reg_addr == FBR_PAT_DATA_OFS && state_q == FBR_ST_IDLE;

    always_comb begin
        rd_ctrl_d = rd_ctrl_q;
        pat_en_d = pat_en_q;
        base_d = base_q;
        pdisp_d = pdisp_q;
        sdisp_d = sdisp_q;
        wr_ctrl_d = wr_ctrl_q;
        pidx_d = pidx_q;
        rdata_d = FBR_REG_RESET;
        if (reg_wr) begin
            case (reg_addr)
                FBR_READ_CTRL_OFS: rd_ctrl_d = {18'h00000, reg_wdata[13:0]};
                FBR_PATTERN_CTRL_OFS: pat_en_d = reg_wdata[FBR_PAT_EN_BIT];
                FBR_WINDOW_BASE_OFS: base_d = reg_wdata[FBR_ADDR_W-1:0]; // see R20
                FBR_BUF_DISP_OFS: pdisp_d = reg_wdata[FBR_ADDR_W-1:0]; // see R21
                FBR_SRC_DISP_OFS: sdisp_d = reg_wdata[FBR_ADDR_W-1:0]; // see R21
                FBR_WRITE_CTRL_OFS: wr_ctrl_d = reg_wdata[1:0];
                FBR_PAT_INDEX_OFS: pidx_d = reg_wdata[FBR_IDX_W-1:0];
                FBR_PAT_DATA_OFS: pidx_d = host_st_wr ? pidx_q + 5'h01 : pidx_q;
                default: ;
            endcase
        end
        if (reg_rd) begin
            case (reg_addr)
                FBR_READ_CTRL_OFS: rdata_d = rd_ctrl_q;
                FBR_PATTERN_CTRL_OFS: rdata_d = {31'h0, pat_en_q};
                FBR_WINDOW_BASE_OFS: rdata_d = {8'h00, base_q};
                FBR_BUF_DISP_OFS: rdata_d = {8'h00, pdisp_q};
                FBR_SRC_DISP_OFS: rdata_d = {8'h00, sdisp_q};
                FBR_WRITE_CTRL_OFS: rdata_d = {30'h0, wr_ctrl_q};
                FBR_PAT_INDEX_OFS: rdata_d = {27'h0, pidx_q};
                FBR_PAT_DATA_OFS: rdata_d = store_q[pidx_q];
                FBR_STATUS_OFS: rdata_d = {24'h0, 1'b0, mode_q, 1'b0, state_q};
                default: rdata_d = FBR_REG_RESET;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            rd_ctrl_q <= FBR_REG_RESET;
            pat_en_q <= 1'b0;
            base_q <= '0;
            pdisp_q <= '0;
            sdisp_q <= '0;
            wr_ctrl_q <= 2'h0;
            pidx_q <= '0;
            rdata_q <= FBR_REG_RESET;
        end else begin
            rd_ctrl_q <= rd_ctrl_d;
            pat_en_q <= pat_en_d;
            base_q <= base_d;
            pdisp_q <= pdisp_d;
            sdisp_q <= sdisp_d;
            wr_ctrl_q <= wr_ctrl_d;
            pidx_q <= pidx_d;
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata = rdata_q;

    // ****************************************
    // Pattern store
    // ****************************************
    // Engine writes win over the host port
    always_comb begin
        st_we = 1'b0;
        st_idx = pidx_q;
        st_wdata = reg_wdata;
        if (state_q == FBR_ST_SRC_WAIT && mem_rsp_valid) begin
            st_we = 1'b1; // see R4, R5, R8
            st_idx = idx_q;
            st_wdata = mem_rsp_data;
        end else if (state_q == FBR_ST_DST_WAIT && mem_rsp_valid && mode_q == 3'h1) begin
            st_we = 1'b1; // see R3
            st_idx = idx_q;
            st_wdata = mem_rsp_data;
        end else if (host_st_wr) begin
            st_we = 1'b1;
        end
    end

    // One entry per flip-flop word, reset-free storage
    for (genvar i = 0; i < FBR_STORE_DEPTH; i++) begin : g_store
        logic [31:0] ent_d;
        always_comb begin
            ent_d = (st_we && st_idx == FBR_IDX_W'(i)) ? st_wdata : store_q[i];
        end
        always_ff @(posedge clock) begin
            store_q[i] <= ent_d; // see R22
        end
    end

    // ****************************************
    // Span sequencer
    // ****************************************
    // A new span waits for the last operand to leave, so modes never mix
    assign accept = span_valid && span_ready;
    assign span_ready = state_q == FBR_ST_IDLE && !out_valid_q;
    assign mem_req_valid = (state_q == FBR_ST_SRC_REQ || state_q == FBR_ST_DST_REQ)
                           && span_q.mask[idx_q] && !out_valid_q;

    always_comb begin
        state_d = state_q;
        mode_d = mode_q;
        span_d = span_q;
        idx_d = idx_q;
        sbase_d = sbase_q;
        dbase_d = dbase_q;
        out_valid_d = out_valid_q && !out_ready;
        out_d = out_q;
        done_d = 1'b0;
        case (state_q)
            FBR_ST_IDLE: begin
                if (accept) begin
                    mode_d = {pat_en_q, rd_ctrl_q[FBR_SRC_RD_BIT], rd_ctrl_q[FBR_DST_RD_BIT]}; // see R1, R23
                    span_d = span_in;
                    idx_d = '0;
                    sbase_d = calc_src;
                    dbase_d = calc_dst;
                    if (mode_d[1]) begin
                        state_d = FBR_ST_SRC_REQ; // see R5
                    end else if (mode_d[0]) begin
                        state_d = FBR_ST_DST_REQ;
                    end else if (mode_d[2]) begin
                        state_d = FBR_ST_PAT; // see R6
                    end else begin
                        done_d = 1'b1; // see R2
                    end
                end
            end
            FBR_ST_SRC_REQ, FBR_ST_DST_REQ: begin
                if (!span_q.mask[idx_q]) begin
                    // Masked words are skipped, not read
                    if (idx_q == FBR_IDX_LAST) begin
                        idx_d = '0;
                        state_d = (state_q == FBR_ST_SRC_REQ && mode_q[0]) ? FBR_ST_DST_REQ : FBR_ST_IDLE;
                        done_d = state_d == FBR_ST_IDLE;
                    end else begin
                        idx_d = idx_q + 5'h01;
                    end
                end else if (mem_req_valid && mem_req_ready) begin
                    state_d = state_q == FBR_ST_SRC_REQ ? FBR_ST_SRC_WAIT : FBR_ST_DST_WAIT;
                end
            end
            FBR_ST_SRC_WAIT, FBR_ST_DST_WAIT: begin
                if (mem_rsp_valid) begin
                    if (state_q == FBR_ST_DST_WAIT) begin
                        // Destination paired with store data, or alone
                        out_valid_d = 1'b1; // see R3, R5, R7
                        out_d.dst = mem_rsp_data;
                        out_d.src = mode_q[2:1] == 2'b00 ? 32'h0000_0000 : store_q[idx_q];
                    end else if (mode_q == 3'h2) begin
                        out_valid_d = 1'b1; // see R4
                        out_d.src = mem_rsp_data;
                        out_d.dst = 32'h0000_0000;
                    end
                    if (idx_q == FBR_IDX_LAST) begin
                        idx_d = '0;
                        state_d = (state_q == FBR_ST_SRC_WAIT && mode_q[0]) ? FBR_ST_DST_REQ : FBR_ST_IDLE;
                        done_d = state_d == FBR_ST_IDLE;
                    end else begin
                        idx_d = idx_q + 5'h01;
                        state_d = state_q == FBR_ST_SRC_WAIT ? FBR_ST_SRC_REQ : FBR_ST_DST_REQ;
                    end
                end
            end
            FBR_ST_PAT: begin
                if (!span_q.mask[idx_q] || !out_valid_q) begin
                    if (span_q.mask[idx_q]) begin
                        out_valid_d = 1'b1; // see R6
                        out_d.src = store_q[idx_q];
                        out_d.dst = 32'h0000_0000;
                    end
                    idx_d = idx_q + 5'h01;
                    if (idx_q == FBR_IDX_LAST) begin
                        state_d = FBR_ST_IDLE;
                        done_d = 1'b1;
                    end
                end
            end
            default: state_d = FBR_ST_IDLE;
        endcase
        addr_d = (state_d == FBR_ST_DST_REQ ? dbase_d : sbase_d) + {19'h0, idx_d}; // see R12, R13, R24
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            state_q <= FBR_ST_IDLE;
            mode_q <= FBR_MODE_NONE;
            span_q <= '0;
            idx_q <= '0;
            sbase_q <= '0;
            dbase_q <= '0;
            addr_q <= '0;
            out_valid_q <= 1'b0;
            out_q <= '0;
            done_q <= 1'b0;
        end else begin
            state_q <= state_d;
            mode_q <= mode_d;
            span_q <= span_d;
            idx_q <= idx_d;
            sbase_q <= sbase_d;
            dbase_q <= dbase_d;
            addr_q <= addr_d;
            out_valid_q <= out_valid_d;
            out_q <= out_d;
            done_q <= done_d;
        end
    end

    assign mem_req_addr = addr_q;
    assign out_valid = out_valid_q;
    assign out_data = out_q;
    assign span_done = done_q;
    assign wr_addr = dbase_q; // see R12
    // Pattern load with variable colour has no data to draw
    assign draw_enable = wr_ctrl_q[FBR_WR_EN_BIT]
                         && !(mode_q == FBR_MODE_PAT_LOAD && wr_ctrl_q[FBR_VAR_COLOUR_BIT]); // see R9

    // ****************************************
    // Assertions
    // ****************************************
    sequence s_busy;
        state_q != FBR_ST_IDLE;
    endsequence

    property p_none_idle;
        @(posedge clock) disable iff (rst) accept && mode_d == FBR_MODE_NONE |=> state_q == FBR_ST_IDLE && span_done;
    endproperty
    a_none_idle: assert property (p_none_idle) else $error("mode none left idle"); // see R2

    property p_src_first;
        @(posedge clock) disable iff (rst) accept && mode_d[1] |=> state_q == FBR_ST_SRC_REQ && idx_q == 5'h00;
    endproperty
    a_src_first: assert property (p_src_first) else $error("source phase not first"); // see R5

    property p_src_addr;
        @(posedge clock) disable iff (rst) mem_req_valid && state_q == FBR_ST_SRC_REQ
            |-> mem_req_addr == sbase_q + {19'h0, idx_q};
    endproperty
    a_src_addr: assert property (p_src_addr) else $error("bad source address"); // see R13

    property p_dst_addr;
        @(posedge clock) disable iff (rst) mem_req_valid && state_q == FBR_ST_DST_REQ
            |-> mem_req_addr == dbase_q + {19'h0, idx_q};
    endproperty
    a_dst_addr: assert property (p_dst_addr) else $error("bad destination address"); // see R12

    property p_mode_hold;
        @(posedge clock) disable iff (rst) s_busy ##1 s_busy |-> $stable(mode_q);
    endproperty
    a_mode_hold: assert property (p_mode_hold) else $error("mode changed mid span"); // see R23

    property p_keep_store;
        @(posedge clock) disable iff (rst) s_busy and mode_q == FBR_MODE_PAT_DST |-> !st_we;
    endproperty
    a_keep_store: assert property (p_keep_store) else $error("store touched in reuse mode"); // see R7

    property p_pat_no_read;
        @(posedge clock) disable iff (rst) s_busy and mode_q == FBR_MODE_PAT_ONLY |-> !mem_req_valid;
    endproperty
    a_pat_no_read: assert property (p_pat_no_read) else $error("read in pattern mode"); // see R6

    property p_load_no_out;
        @(posedge clock) disable iff (rst) s_busy and mode_q == FBR_MODE_PAT_LOAD |=> !out_valid_q;
    endproperty
    a_load_no_out: assert property (p_load_no_out) else $error("output in pattern load"); // see R8

    property p_load_draw;
        @(posedge clock) disable iff (rst) mode_q == FBR_MODE_PAT_LOAD && wr_ctrl_q == 2'h3 |-> !draw_enable;
    endproperty
    a_load_draw: assert property (p_load_draw) else $error("variable colour drew in load"); // see R9

endmodule // fbr_span_read

//--- tb/fbr_mem_model.sv
`timescale 1ns/1ps
// Far side: framebuffer memory controller plus a stalling logic-op sink
module fbr_mem_model (
    input wire logic clock,
    input wire logic rst,
    input wire logic mem_req_valid,
    input wire logic [23:0] mem_req_addr,
    output logic mem_req_ready,
    output logic mem_rsp_valid,
    output logic [31:0] mem_rsp_data,
    output logic out_ready
);
    int seed = 70;
    int wait_n = 0;
    logic pend = 1'b0;
    logic [23:0] held = 24'h0;
    // Quiet outputs before the first edge
    initial begin
        mem_req_ready = 1'b0;
        mem_rsp_valid = 1'b0;
        mem_rsp_data = 32'h0;
        out_ready = 1'b0;
    end
    // Data carries its own address so the bench can see which word was read
    always @(posedge clock) begin
        mem_rsp_valid <= 1'b0;
        mem_rsp_data <= ~mem_rsp_data; // Idle data keeps moving, never stale
        mem_req_ready <= ($random(seed) & 3) != 0;
        out_ready <= ($random(seed) & 3) != 0;
        if (mem_req_valid && mem_req_ready && !pend) begin
            pend <= 1'b1;
            held <= mem_req_addr;
            wait_n <= $random(seed) & 3;
        end else if (pend && wait_n > 0) begin
            wait_n <= wait_n - 1;
        end else if (pend) begin
            mem_rsp_valid <= 1'b1;
            mem_rsp_data <= {8'h5A, held};
            pend <= 1'b0;
        end
        if (rst) begin
            pend <= 1'b0;
        end
    end
endmodule // fbr_mem_model

//--- tb/fbr_span_read_tb.sv
`timescale 1ns/1ps
module fbr_span_read_tb;
    import fbr_pkg::*;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic span_valid = 1'b0;
    fbr_span_s span_in = '0;
    logic [31:0] reg_rdata, mem_rsp_data;
    logic span_ready, span_done, mem_req_valid, mem_req_ready, mem_rsp_valid, out_valid, out_ready, draw_enable;
    logic [23:0] mem_req_addr, wr_addr, base, pix, sdisp, dst_a, src_a;
    fbr_pair_s out_data;
    fbr_pair_s exp_q[$];
    logic [31:0] ld_data [32];
    int fails = 0;
    int tests_run = 0;
    int cycles = 0;
    int seed = 70;
    always #2 clock = ~clock;
    fbr_span_read fbr_span_read_inst (.clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .span_valid(span_valid), .span_in(span_in),
        .span_ready(span_ready), .span_done(span_done), .mem_req_valid(mem_req_valid),
        .mem_req_addr(mem_req_addr), .mem_req_ready(mem_req_ready), .mem_rsp_valid(mem_rsp_valid),
        .mem_rsp_data(mem_rsp_data), .out_valid(out_valid), .out_data(out_data), .out_ready(out_ready),
        .wr_addr(wr_addr), .draw_enable(draw_enable));
    fbr_mem_model fbr_mem_model_inst (.clock(clock), .rst(rst), .mem_req_valid(mem_req_valid),
        .mem_req_addr(mem_req_addr), .mem_req_ready(mem_req_ready), .mem_rsp_valid(mem_rsp_valid),
        .mem_rsp_data(mem_rsp_data), .out_ready(out_ready));
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask
    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clock);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        @(negedge clock);
        check({32'h0, reg_rdata}, {32'h0, e});
    endtask
    // Random geometry per span; expected operand pairs queued from the address equations
    task automatic span(input logic [2:0] m, input logic [31:0] mask);
        logic [15:0] x;
        logic [15:0] y;
        logic [13:0] ctl;
        logic [31:0] s;
        logic [31:0] d;
        int w;
        int n;
        ctl = 14'($random(seed));
        ctl[1:0] = {m[0], m[1]};
        w = 0;
        for (int k = 0; k < 3; k++)
            if (ctl[2+3*k +: 3] != 3'h0) w += 16 << ctl[2+3*k +: 3];
        x = 16'($random(seed));
        y = 16'($random(seed));
        dst_a = ctl[11] ? 24'(base + pix + x + (y >> ctl[13:12]) * w) : 24'(base + pix + x - (y >> ctl[13:12]) * w);
        src_a = dst_a + sdisp;
        wr(FBR_PATTERN_CTRL_OFS, {31'h0, m[2]});
        wr(FBR_READ_CTRL_OFS, {18'h0, ctl});
        for (int i = 0; i < 32; i++) begin
            s = {8'h5A, 24'(src_a + i)};
            d = {8'h5A, 24'(dst_a + i)};
            if (mask[i] && m[1:0] == 2'h3) exp_q.push_back({s, d});
            if (mask[i] && m == 3'h1) exp_q.push_back({32'h0, d});
            if (mask[i] && m == 3'h2) exp_q.push_back({s, 32'h0});
            if (mask[i] && m == 3'h4) exp_q.push_back({ld_data[i], 32'h0});
            if (mask[i] && m == 3'h5) exp_q.push_back({ld_data[i], d});
            if (mask[i] && m == 3'h6) ld_data[i] = s;
        end
        @(posedge clock);
        span_in <= '{x: x, y: y, mask: mask};
        span_valid <= 1'b1;
        do @(negedge clock); while (span_ready !== 1'b1);
        @(posedge clock);
        span_valid <= 1'b0;
        n = 0;
        do begin
            @(negedge clock);
            n++;
        end while (span_done !== 1'b1);
        if (m == 3'h0) check(64'(n), 64'h1);
        check({40'h0, wr_addr}, {40'h0, dst_a});
        wr(FBR_WRITE_CTRL_OFS, 32'h3);
        @(negedge clock);
        check({63'h0, draw_enable}, {63'h0, m != 3'h6});
        wr(FBR_WRITE_CTRL_OFS, 32'h1);
        @(negedge clock);
        check({63'h0, draw_enable}, 64'h1);
    endtask
    // Scoreboard on the operand stream, plus the hang limit
    always @(posedge clock) begin
        cycles++;
        if (cycles > 30000) begin
            fails++;
            conclude();
        end else if (out_valid && out_ready) begin
            if (exp_q.size() == 0) check(out_data, ~out_data);
            else check(out_data, exp_q.pop_front());
        end
    end
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        repeat (20) @(posedge clock);
        rst <= 1'b0;
        for (int a = 0; a <= 36; a += 4)
            if (a != 28) rd(8'(a), 32'h0);
        wr(FBR_WINDOW_BASE_OFS, 32'hFFFF_FFFF);
        rd(FBR_WINDOW_BASE_OFS, 32'h00FF_FFFF);
        wr(FBR_PAT_INDEX_OFS, 32'h3);
        wr(FBR_PAT_DATA_OFS, 32'hC0DE_0003);
        rd(FBR_PAT_INDEX_OFS, 32'h4);
        wr(FBR_PAT_INDEX_OFS, 32'h3);
        rd(FBR_PAT_DATA_OFS, 32'hC0DE_0003);
        base = 24'h01_2000;
        pix = 24'h0;
        sdisp = 24'h0;
        wr(FBR_WINDOW_BASE_OFS, {8'h0, base});
        wr(FBR_BUF_DISP_OFS, 32'h0);
        wr(FBR_SRC_DISP_OFS, 32'h0);
        span(3'h1, $random(seed));
        span(3'h2, $random(seed));
        base = 24'hFFF000;
        pix = 24'hFFFFF0;
        sdisp = 24'h004000;
        wr(FBR_WINDOW_BASE_OFS, {8'h0, base});
        wr(FBR_BUF_DISP_OFS, {8'hFF, pix});
        wr(FBR_SRC_DISP_OFS, {8'h0, sdisp});
        span(3'h3, $random(seed));
        span(3'h7, $random(seed));
        span(3'h6, 32'hFFFF_FFFF);
        span(3'h4, $random(seed));
        pix = 24'h000800;
        wr(FBR_BUF_DISP_OFS, {8'h0, pix});
        span(3'h5, $random(seed));
        span(3'h4, $random(seed));
        span(3'h0, $random(seed));
        wr(FBR_WRITE_CTRL_OFS, 32'h1);
        @(negedge clock);
        check({63'h0, draw_enable}, 64'h1);
        repeat (10) @(posedge clock);
        check(64'(exp_q.size()), 64'h0);
        conclude();
    end
endmodule // fbr_span_read_tb
